// ### inc/mom_pkg.sv
// package for the multiport operand memory: address map, bus carriers
// assumes one core clock; all bus requests synchronous to it
package mom_pkg;
	// logical page bases (local bus view)
	localparam logic [31:0] A_PAGE0_BASE = 32'hA500_7000;
	localparam logic [31:0] A_PAGE1_BASE = 32'hA500_8000;
	localparam logic [31:0] B_PAGE0_BASE = 32'hA501_7000;
	localparam logic [31:0] B_PAGE1_BASE = 32'hA501_8000;
	// physical view clears the top address bits
	localparam int PHYS_CLEAR_BITS = 3;
	// operand buses ignore the upper half of the address
	localparam int OPND_ADDR_BITS = 16;
	// page geometry
	localparam int PAGE_OFF_BITS = 12;
	localparam int WORD_BITS = 10;
	localparam int PAGE_WORDS = 1024;
	localparam int NUM_MEM = 2;
	localparam int NUM_PAGE = 2;
	localparam int NUM_PORT = 3;
	// port indices, also the grant priority order (lowest wins)
	localparam int PORT_SYS = 0;
	localparam int PORT_OPND = 1;
	localparam int PORT_LOC = 2;
	// system bus wait cycles, spent in SYS_WAIT before the GO cycle uses the array
	localparam int SYS_WAIT_CYCLES = 2;

	// one bus request: valid, write, address, byte enables, write data
	typedef struct packed {
		logic req;
		logic wr;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} mom_req_type;

	// one bus answer: ready pulse, read data
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} mom_rsp_type;

	// system bus delay states
	typedef enum logic [2:0] {
		SYS_IDLE = 3'b001,
		SYS_WAIT = 3'b010,
		SYS_GO = 3'b100
	} mom_sys_type;
endpackage : mom_pkg

// ### src/mom_core.sv
// multiport operand memory: two memories, two pages each, three ports
// assumes bus masters hold req until ack; one core clock, async reset
`timescale 1ns/1ps

// Summary of operation
// - two memories, each split into two pages
// - local bus decodes fixed logical page bases
// - system bus decodes bases with top bits cleared
// - operand buses decode only low sixteen bits
// - each page has three ports, one served per cycle
// - local, system, operand spaces map to ports
// - same page priority: system, operand, local
// - local one cycle; system takes several cycles
// - operand one cycle; both operand buses parallel
// - conflicting accesses all complete correctly
// - different pages or memories never conflict
// - sleep refuses system bus accesses
module mom_core (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// chip sleep state
	input wire logic sleep_mode,
	// system bus, physical addresses, one port for both memories
	input wire mom_pkg::mom_req_type sys_req,
	output mom_pkg::mom_rsp_type sys_rsp,
	output logic sys_refused,
	// local bus, logical addresses
	input wire mom_pkg::mom_req_type loc_req,
	output mom_pkg::mom_rsp_type loc_rsp,
	// first operand bus (memory a) and second (memory b)
	input wire mom_pkg::mom_req_type opa_req,
	output mom_pkg::mom_rsp_type opa_rsp,
	input wire mom_pkg::mom_req_type opb_req,
	output mom_pkg::mom_rsp_type opb_rsp
);
	// decoded target: hit, memory, page, word index
	typedef struct packed {
		logic hit;
		logic mem;
		logic page;
		logic [9:0] word;
	} mom_dec_type;

	// all registered state
	typedef struct packed {
		mom_pkg::mom_sys_type sys_st;
		logic [1:0] sys_cnt;
		mom_pkg::mom_rsp_type sys_rsp;
		mom_pkg::mom_rsp_type loc_rsp;
		mom_pkg::mom_rsp_type opa_rsp;
		mom_pkg::mom_rsp_type opb_rsp;
		logic sys_refused;
	} mom_state_type;

	// page storage: memory, page, word
	logic [31:0] mem_array [mom_pkg::NUM_MEM*mom_pkg::NUM_PAGE]
		[mom_pkg::PAGE_WORDS];

	mom_state_type st;
	mom_state_type next_st;

	// masked decode of the page bits against the four page bases
	function automatic mom_dec_type mom_decode(input logic [31:0] a,
		input logic [31:0] mask);
		mom_dec_type d;
		logic [31:0] page_base;
		d = '0;
		page_base = {a[31:12], 12'h000} & mask;
		d.word = a[11:2];
		if (page_base == (mom_pkg::A_PAGE0_BASE & mask)) begin
			d.hit = 1'b1;
		end else if (page_base == (mom_pkg::A_PAGE1_BASE & mask)) begin
			d.hit = 1'b1;
			d.page = 1'b1;
		end else if (page_base == (mom_pkg::B_PAGE0_BASE & mask)) begin
			d.hit = 1'b1;
			d.mem = 1'b1;
		end else if (page_base == (mom_pkg::B_PAGE1_BASE & mask)) begin
			d.hit = 1'b1;
			d.mem = 1'b1;
			d.page = 1'b1;
		end
		return d;
	endfunction : mom_decode

	// address masks per view
	localparam logic [31:0] LOC_MASK = 32'hFFFF_FFFF;
	localparam logic [31:0] SYS_MASK = 32'hFFFF_FFFF
		>> mom_pkg::PHYS_CLEAR_BITS;
	localparam logic [31:0] OPND_MASK = ~(32'hFFFF_FFFF
		<< mom_pkg::OPND_ADDR_BITS);

	mom_dec_type sys_dec, loc_dec, opa_dec, opb_dec;
	logic sys_dec_ok;

	// decode each bus in its own address space
	always_comb begin
		sys_dec = mom_decode(sys_req.addr, SYS_MASK);
		loc_dec = mom_decode(loc_req.addr, LOC_MASK);
		opa_dec = mom_decode(opa_req.addr, OPND_MASK);
		opb_dec = mom_decode(opb_req.addr, OPND_MASK);
		// system addresses must have the top bits clear
		sys_dec_ok = sys_dec.hit && (sys_req.addr[31:29] == 3'b000);
	end

	// per-page port requests and grants
	logic [3:0][2:0] page_req;
	logic [3:0][2:0] page_gnt;
	logic [3:0][9:0] page_word [3];
	logic sys_go;

	assign sys_go = (st.sys_st == mom_pkg::SYS_GO);

	// route each bus to its page; operand buses only reach their memory
	always_comb begin
		page_req = '0;
		for (int p = 0; p < 4; p++) begin
			page_word[0][p] = sys_dec.word;
			page_word[1][p] = p[1] ? opb_dec.word : opa_dec.word;
			page_word[2][p] = loc_dec.word;
			page_req[p][mom_pkg::PORT_SYS] = sys_go && sys_dec_ok
				&& ({sys_dec.mem, sys_dec.page} == p[1:0]);
			// both memories share the low half of their bases, so
			// the bus, not the decoded memory bit, picks the memory
			page_req[p][mom_pkg::PORT_OPND] = p[1]
				? (opb_req.req && opb_dec.hit && opb_dec.page == p[0])
				: (opa_req.req && opa_dec.hit
					&& opa_dec.page == p[0]);
			page_req[p][mom_pkg::PORT_LOC] = loc_req.req && loc_dec.hit
				&& ({loc_dec.mem, loc_dec.page} == p[1:0]);
		end
	end

	// fixed priority per page; pages arbitrate independently
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++) begin : g_page
			always_comb begin
				page_gnt[gp] = '0;
				if (page_req[gp][0]) begin
					page_gnt[gp][0] = 1'b1;
				end else if (page_req[gp][1]) begin
					page_gnt[gp][1] = 1'b1;
				end else if (page_req[gp][2]) begin
					page_gnt[gp][2] = 1'b1;
				end
			end
		end
	endgenerate

	// per-bus grant collapsed over pages
	logic sys_gnt, loc_gnt, opa_gnt, opb_gnt;
	always_comb begin
		sys_gnt = |{page_gnt[3][0], page_gnt[2][0], page_gnt[1][0],
			page_gnt[0][0]};
		loc_gnt = |{page_gnt[3][2], page_gnt[2][2], page_gnt[1][2],
			page_gnt[0][2]};
		opa_gnt = page_gnt[0][1] | page_gnt[1][1];
		opb_gnt = page_gnt[2][1] | page_gnt[3][1];
	end

	// write-and-read of the granted port on each page
	function automatic logic [31:0] mom_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction : mom_merge

	// array writes; one port per page per cycle keeps data intact
	always_ff @(posedge sys_clk) begin
		for (int p = 0; p < 4; p++) begin
			if (page_gnt[p][0] && sys_req.wr) begin
				mem_array[p][page_word[0][p]] <= mom_merge(
					mem_array[p][page_word[0][p]], sys_req.wdata,
					sys_req.be);
			end else if (page_gnt[p][1] && (p[1] ? opb_req.wr
				: opa_req.wr)) begin
				mem_array[p][page_word[1][p]] <= mom_merge(
					mem_array[p][page_word[1][p]],
					p[1] ? opb_req.wdata : opa_req.wdata,
					p[1] ? opb_req.be : opa_req.be);
			end else if (page_gnt[p][2] && loc_req.wr) begin
				mem_array[p][page_word[2][p]] <= mom_merge(
					mem_array[p][page_word[2][p]], loc_req.wdata,
					loc_req.be);
			end
		end
	end

	// next state: answers, system bus wait sequencer, sleep refusal
	always_comb begin
		next_st = st;
		next_st.sys_rsp.ack = 1'b0;
		next_st.loc_rsp.ack = 1'b0;
		next_st.opa_rsp.ack = 1'b0;
		next_st.opb_rsp.ack = 1'b0;
		next_st.sys_refused = 1'b0;
		// local and operand buses answer the cycle after grant
		if (loc_gnt) begin
			next_st.loc_rsp.ack = 1'b1;
			next_st.loc_rsp.rdata =
				mem_array[{loc_dec.mem, loc_dec.page}][loc_dec.word];
		end
		if (opa_gnt) begin
			next_st.opa_rsp.ack = 1'b1;
			next_st.opa_rsp.rdata =
				mem_array[{1'b0, opa_dec.page}][opa_dec.word];
		end
		if (opb_gnt) begin
			next_st.opb_rsp.ack = 1'b1;
			next_st.opb_rsp.rdata =
				mem_array[{1'b1, opb_dec.page}][opb_dec.word];
		end
		// system bus: wait states model the bus's multi-cycle access
		case (st.sys_st)
			mom_pkg::SYS_IDLE: begin
				if (sys_req.req && sleep_mode) begin
					next_st.sys_refused = 1'b1;
				end else if (sys_req.req && sys_dec_ok) begin
					next_st.sys_st = mom_pkg::SYS_WAIT;
					next_st.sys_cnt = 2'(mom_pkg::SYS_WAIT_CYCLES - 1);
				end
			end
			mom_pkg::SYS_WAIT: begin
				if (st.sys_cnt == 2'h0) begin
					next_st.sys_st = mom_pkg::SYS_GO;
				end else begin
					next_st.sys_cnt = st.sys_cnt - 2'h1;
				end
			end
			mom_pkg::SYS_GO: begin
				next_st.sys_st = mom_pkg::SYS_IDLE;
				next_st.sys_rsp.ack = sys_gnt; // system never loses a page
				next_st.sys_rsp.rdata =
					mem_array[{sys_dec.mem, sys_dec.page}][sys_dec.word];
			end
			default: begin
				next_st.sys_st = mom_pkg::SYS_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '{sys_st: mom_pkg::SYS_IDLE, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign sys_rsp = st.sys_rsp;
	assign loc_rsp = st.loc_rsp;
	assign opa_rsp = st.opa_rsp;
	assign opb_rsp = st.opb_rsp;
	assign sys_refused = st.sys_refused;

	// local access to a free page acks next cycle
	AST_LOC_ONE_CYCLE: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		loc_req.req && loc_dec.hit && !(|(page_req[{loc_dec.mem,
		loc_dec.page}][1:0])) |=> loc_rsp.ack)
		else $error("local access not answered in one cycle");

	// system access answered exactly four cycles after it starts
	sequence s_sys_start;
		st.sys_st == mom_pkg::SYS_IDLE && sys_req.req && sys_dec_ok
			&& !sleep_mode;
	endsequence
	AST_SYS_LATENCY: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		s_sys_start |=> !sys_rsp.ack [*2] ##1 !sys_rsp.ack ##1 sys_rsp.ack)
		else $error("system access latency wrong");

	// sleep refuses and never starts a system access
	AST_SLEEP_REFUSE: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		st.sys_st == mom_pkg::SYS_IDLE && sys_req.req && sleep_mode
		|=> sys_refused && st.sys_st == mom_pkg::SYS_IDLE)
		else $error("system access not refused in sleep");

	// both operand buses served together on free pages
	AST_OPND_PARALLEL: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		opa_gnt && opb_gnt |=> opa_rsp.ack && opb_rsp.ack)
		else $error("operand buses not parallel");

	// system bus beats operand bus on the same page
	AST_PRIO_SYS: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		page_req[2][0] && page_req[2][1] |=> sys_rsp.ack
		&& !opb_rsp.ack)
		else $error("system bus lost priority");

	// operand bus beats local bus on the same page
	AST_PRIO_OPND: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		!page_req[2][0] && page_req[2][1] && page_req[2][2]
		|=> opb_rsp.ack && !loc_rsp.ack)
		else $error("operand bus lost priority");

	// local on another page than both operand buses is not delayed
	AST_NO_CONFLICT: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		opa_gnt && loc_req.req && loc_dec.hit && loc_dec.mem
		&& !page_req[{1'b1, loc_dec.page}][1]
		&& !sys_go |=> loc_rsp.ack)
		else $error("different pages conflicted");

	// system address with top bits set never starts
	AST_SYS_DECODE: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		st.sys_st == mom_pkg::SYS_IDLE && sys_req.req
		&& sys_req.addr[31:29] != 3'b000 |=> st.sys_st
		== mom_pkg::SYS_IDLE)
		else $error("system decode ignored top bits");
endmodule : mom_core

// ### verif/mom_master.sv
// bus master model for one port of the operand memory
// assumes requests launched on the falling edge; held until ack or refusal
`timescale 1ns/1ps
module mom_master (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// command from the bench
	input wire logic go,
	input wire mom_pkg::mom_req_type cmd,
	// bus toward the memory
	input wire mom_pkg::mom_rsp_type rsp,
	input wire logic refused,
	output mom_pkg::mom_req_type req,
	// result to the bench
	output logic done,
	output logic [31:0] rdata
);
	initial begin
		req <= '0;
		done <= 1'b0;
		rdata <= '0;
	end

	// issue, hold until answered, then release the bus
	always @(negedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			req <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (req.req && (rsp.ack || refused)) begin
				// released address and data show inverted junk, not the old value
				req.req <= 1'b0;
				req.addr <= ~req.addr;
				req.wdata <= ~req.wdata;
				done <= 1'b1;
				rdata <= rsp.rdata;
			end else if (go && !req.req) begin
				req <= cmd;
			end
		end
	end
endmodule : mom_master

// ### verif/tb_mom_core.sv
// self-checking bench for the multiport operand memory
// assumes four master models: 0 system, 1 local, 2 operand a, 3 operand b
`timescale 1ns/1ps
module tb_mom_core;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic sleep_mode = 1'b0;
	logic sys_refused;
	logic [3:0] go = 4'h0;
	mom_pkg::mom_req_type cmd [4];
	wire mom_pkg::mom_req_type rq [4];
	wire mom_pkg::mom_rsp_type rs [4];
	wire [3:0] done;
	wire [31:0] rd [4];
	int cnt [4];
	int error_cnt = 0;
	int n_tests = 0;
	logic [31:0] base [4];

	always #2.5 sys_clk = ~sys_clk;

	mom_core u_mom_core (.sys_clk(sys_clk), .resetn(resetn),
		.sleep_mode(sleep_mode), .sys_req(rq[0]), .sys_rsp(rs[0]),
		.sys_refused(sys_refused), .loc_req(rq[1]), .loc_rsp(rs[1]),
		.opa_req(rq[2]), .opa_rsp(rs[2]), .opb_req(rq[3]), .opb_rsp(rs[3]));

	// one master model per bus
	for (genvar i = 0; i < 4; i++) begin : g_m
		mom_master u_mom_master (.sys_clk(sys_clk), .resetn(resetn),
			.go(go[i]), .cmd(cmd[i]), .rsp(rs[i]),
			.refused(i == 0 ? sys_refused : 1'b0), .req(rq[i]),
			.done(done[i]), .rdata(rd[i]));
	end

	task complete_run();
		$display("errors %0d tests %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk

	task set(input int i, input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		cmd[i] = '{1'b1, wr, a, 4'hf, d};
	endtask : set

	// launch m together, late lag cycles after; cnt counts posedges
	// from the first launch until each master finished
	task xfer_lag(input logic [3:0] m, input logic [3:0] late,
		input int lag);
		cnt = '{default: 0};
		@(negedge sys_clk);
		go <= m;
		for (int c = 1; c <= 30; c++) begin
			@(negedge sys_clk);
			go <= (c == lag) ? late : 4'h0;
			@(posedge sys_clk);
			for (int i = 0; i < 4; i++)
				if ((m[i] || late[i]) && done[i] === 1'b1
					&& cnt[i] == 0)
					cnt[i] = c;
		end
		for (int i = 0; i < 4; i++)
			if ((m[i] || late[i]) && cnt[i] == 0) begin
				$display("wrong value at %0t: no answer on bus %h", $time, i);
				error_cnt++;
				complete_run();
			end
	endtask : xfer_lag

	// launch masters together
	task xfer(input logic [3:0] m);
		xfer_lag(m, 4'h0, 0);
	endtask : xfer

	// write last word of each page locally, read back on other views
	task t_map();
		logic [31:0] a;
		for (int p = 0; p < 4; p++) begin
			a = base[p] + 32'h0000_0ffc;
			set(1, 1'b1, a, 32'h5a00_0000 + p);
			xfer(4'b0010);
			chk(cnt[1], 2);
			set(0, 1'b0, (a << mom_pkg::PHYS_CLEAR_BITS)
				>> mom_pkg::PHYS_CLEAR_BITS, 0);
			xfer(4'b0001);
			chk(cnt[0], mom_pkg::SYS_WAIT_CYCLES + 3);
			chk(rd[0], 32'h5a00_0000 + p);
			set(2 + p / 2, 1'b0, {16'hbeef, a[15:0]}, 0);
			xfer(4'b0100 << (p / 2));
			chk(cnt[2 + p / 2], 2);
			chk(rd[2 + p / 2], 32'h5a00_0000 + p);
		end
	endtask : t_map

	// both operand buses, and local on memory b's other page, at once
	task t_par();
		set(2, 1'b0, 32'h0000_7ffc, 0);
		set(3, 1'b0, 32'h0000_7ffc, 0);
		set(1, 1'b0, base[3] + 32'h0000_0ffc, 0);
		xfer(4'b1110);
		for (int i = 1; i < 4; i++)
			chk(cnt[i], 2);
		chk(rd[2], 32'h5a00_0000);
		chk(rd[3], 32'h5a00_0002);
		chk(rd[1], 32'h5a00_0003);
	endtask : t_par

	// three buses write one page at once; priority, nothing lost
	task t_conflict();
		set(0, 1'b1, base[0] & 32'h1fff_ffff, 32'h1111_0000);
		set(2, 1'b1, 32'h0000_7004, 32'h2222_0000);
		set(1, 1'b1, base[0] + 32'h0000_0008, 32'h3333_0000);
		xfer(4'b0111);
		chk(cnt[0], mom_pkg::SYS_WAIT_CYCLES + 3);
		chk(cnt[1] > cnt[2], 1);
		for (int w = 0; w < 3; w++) begin
			set(1, 1'b0, base[0] + 4 * w, 0);
			xfer(4'b0010);
			chk(rd[1], 32'h1111_0000 * (w + 1));
		end
	endtask : t_conflict

	// system, second operand and local meet on one page of memory b
	task t_prio();
		set(0, 1'b1, (base[2] & 32'h1fff_ffff) + 32'h0000_0010,
			32'h4444_0000);
		set(3, 1'b1, 32'h0000_7014, 32'h5555_0000);
		set(1, 1'b1, base[2] + 32'h0000_0018, 32'h6666_0000);
		// late masters land in the cycle the system bus owns the page
		xfer_lag(4'b0001, 4'b1010, mom_pkg::SYS_WAIT_CYCLES + 1);
		chk(cnt[0], mom_pkg::SYS_WAIT_CYCLES + 3);
		chk(cnt[3], mom_pkg::SYS_WAIT_CYCLES + 4);
		chk(cnt[1], mom_pkg::SYS_WAIT_CYCLES + 5);
		for (int w = 0; w < 3; w++) begin
			set(1, 1'b0, base[2] + 32'h0000_0010 + 4 * w, 0);
			xfer(4'b0010);
			chk(rd[1], 32'h4444_0000 + 32'h1111_0000 * w);
		end
	endtask : t_prio

	// system address with top bits set is ignored and writes nothing
	task t_bad();
		int seen;
		seen = 0;
		set(0, 1'b1, base[0], 32'hbad0_0000);
		@(negedge sys_clk);
		go <= 4'h1;
		@(negedge sys_clk);
		go <= 4'h0;
		for (int c = 0; c < 10; c++) begin
			@(posedge sys_clk);
			if (done[0] !== 1'b0)
				seen = 1;
		end
		chk(seen, 0);
		// the stuck request is only taken back by a reset; memory stays
		@(negedge sys_clk);
		resetn = 1'b0;
		@(negedge sys_clk);
		resetn = 1'b1;
		set(1, 1'b0, base[0], 0);
		xfer(4'b0010);
		chk(rd[1], 32'h1111_0000);
	endtask : t_bad

	// system write while asleep is refused and leaves memory alone
	task t_sleep();
		@(negedge sys_clk);
		sleep_mode = 1'b1;
		set(0, 1'b1, base[0] & 32'h1fff_ffff, 32'hdead_0000);
		xfer(4'b0001);
		chk(cnt[0], 2);
		@(negedge sys_clk);
		sleep_mode = 1'b0;
		set(1, 1'b0, base[0], 0);
		xfer(4'b0010);
		chk(rd[1], 32'h1111_0000);
	endtask : t_sleep

	initial begin
		base = '{mom_pkg::A_PAGE0_BASE, mom_pkg::A_PAGE1_BASE,
			mom_pkg::B_PAGE0_BASE, mom_pkg::B_PAGE1_BASE};
		for (int i = 0; i < 4; i++)
			cmd[i] = '0;
		// hold reset two cycles, release off the edge
		repeat (2) @(negedge sys_clk);
		resetn = 1'b1;
		t_map();
		t_par();
		t_conflict();
		t_prio();
		t_sleep();
		t_bad();
		complete_run();
	end
endmodule : tb_mom_core
